// file: core/brk_unit.sv
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`include "brk_regs.svh"
module brk_unit
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Link to the CPU core
    brk_link_if.dev link,
    // Test voltage detector on the reset pin, asynchronous
    input wire logic test_high_voltage,
    // Outputs to the rest of the chip
    output logic timer_halt,
    output logic watchdog_disable,
    output logic flag_clear_allowed
);

    // True when a register access targets the given address
    function automatic logic hit(input brk_pkg::brk_addr_t a,
                                 input brk_pkg::brk_addr_t ofs);
        hit = (a == ofs);
    endfunction

    // Breakpoint address bytes
    brk_pkg::brk_byte_t addr_high_reg;
    brk_pkg::brk_byte_t addr_low_reg;
    // Control and status bits
    logic break_enable_bit_reg;
    logic break_active_bit_reg;
    logic low_power_exit_flag_reg;
    logic flag_clear_enable_reg;
    // Request held until the CPU takes it
    logic pending_reg;
    // Break state machine
    brk_pkg::brk_state_e state_reg;
    // Test voltage synchroniser
    logic tst_meta_reg;
    logic tst_sync_reg;
    // Registered read data
    brk_pkg::brk_byte_t rdata_reg;

    // Decoded writes
    logic wr_high;
    logic wr_low;
    logic wr_scr;
    logic wr_lpe;
    logic wr_fce;
    // Address match and request
    logic match;
    logic in_break;
    logic req;

    assign wr_high = link.reg_wr && hit(link.reg_addr, `BRK_ADDR_HIGH_ADDR);
    assign wr_low = link.reg_wr && hit(link.reg_addr, `BRK_ADDR_LOW_ADDR);
    assign wr_scr = link.reg_wr && hit(link.reg_addr, `BRK_STAT_CTRL_ADDR);
    assign wr_lpe = link.reg_wr && hit(link.reg_addr, `BRK_LPE_STATUS_ADDR);
    assign wr_fce = link.reg_wr && hit(link.reg_addr, `BRK_FLAG_CLR_ADDR);

    assign in_break = (state_reg == brk_pkg::BRK_HALTED);

    // Compare only addresses the program counter drove, full 16 bits
    assign match = break_enable_bit_reg
        && link.addr_is_pc
        && (link.cpu_addr == {addr_high_reg, addr_low_reg})
        && !in_break;

    // The live match joins the held request so that a match on the final
    // cycle of an instruction is seen at that boundary, not one later
    assign req = (match || pending_reg) && !in_break;
    assign link.brk_req = req;
    assign link.break_state = in_break;

    // Wake request while the core sleeps; the core leaves stop or wait
    assign link.wake = req
        && (link.in_stop || link.in_wait);

    // Chip side effects of the break state
    assign timer_halt = in_break;
    assign watchdog_disable = in_break && tst_sync_reg;
    // Peripherals honour status clears only when this is high
    assign flag_clear_allowed = !in_break || flag_clear_enable_reg;
    assign link.reg_rdata = rdata_reg;

    // Two-stage synchroniser for the test voltage detector
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tst_meta_reg <= 1'b0;
            tst_sync_reg <= 1'b0;
        end
        else
        begin
            tst_meta_reg <= test_high_voltage;
            tst_sync_reg <= tst_meta_reg;
        end
    end

    // Breakpoint address bytes, plain read/write
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            addr_high_reg <= `BRK_BYTE_RESET;
            addr_low_reg <= `BRK_BYTE_RESET;
        end
        else
        begin
            // High byte
            if (wr_high)
            begin
                addr_high_reg <= link.reg_wdata;
            end
            // Low byte
            if (wr_low)
            begin
                addr_low_reg <= link.reg_wdata;
            end
        end
    end

    // Break enable, written either way by software
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            break_enable_bit_reg <= 1'b0;
        end
        else if (wr_scr)
        begin
            break_enable_bit_reg <= link.reg_wdata[`BRK_ENABLE_BIT];
        end
    end

    // Break active: a match sets it and wins over a same-cycle clear
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            break_active_bit_reg <= 1'b0;
        end
        else if (match)
        begin
            break_active_bit_reg <= 1'b1;
        end
        else if (wr_scr)
        begin
            // One requests a break, zero clears before leaving
            break_active_bit_reg <= link.reg_wdata[`BRK_ACTIVE_BIT];
        end
    end

    // Held request: set by a match or a software write of one, dropped
    // when the core reports it has taken the break
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pending_reg <= 1'b0;
        end
        else if (link.swi_taken)
        begin
            pending_reg <= 1'b0;
        end
        else if (match)
        begin
            pending_reg <= 1'b1;
        end
        else if (wr_scr && link.reg_wdata[`BRK_ACTIVE_BIT] && !in_break)
        begin
            pending_reg <= 1'b1;
        end
    end

    // Break state: entered when the core takes the interrupt opcode,
    // left on the return from interrupt
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= brk_pkg::BRK_RUN;
        end
        else
        begin
            case (state_reg)
                brk_pkg::BRK_RUN:
                begin
                    // Core vectors to the break routine
                    if (link.swi_taken)
                    begin
                        state_reg <= brk_pkg::BRK_HALTED;
                    end
                end
                brk_pkg::BRK_HALTED:
                begin
                    // Return from interrupt ends the break
                    if (link.rti_done)
                    begin
                        state_reg <= brk_pkg::BRK_RUN;
                    end
                end
                default:
                begin
                    state_reg <= brk_pkg::BRK_RUN;
                end
            endcase
        end
    end

    // Low power exit flag: set wins over a write of zero; writing one
    // leaves it alone. Not gated by the clear enable, since the break
    // routine itself must be able to clear it
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            low_power_exit_flag_reg <= 1'b0;
        end
        else if (link.wake)
        begin
            low_power_exit_flag_reg <= 1'b1;
        end
        else if (wr_lpe && !link.reg_wdata[`BRK_LPE_FLAG_BIT])
        begin
            low_power_exit_flag_reg <= 1'b0;
        end
    end

    // Flag clear enable, plain read/write
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flag_clear_enable_reg <= 1'b0;
        end
        else if (wr_fce)
        begin
            flag_clear_enable_reg <= link.reg_wdata[`BRK_FCE_BIT];
        end
    end

    // Read data, registered one cycle after the read strobe
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_reg <= `BRK_BYTE_RESET;
        end
        else if (link.reg_rd)
        begin
            // Unused and reserved bits read as zero
            rdata_reg <= `BRK_BYTE_RESET;
            if (hit(link.reg_addr, `BRK_ADDR_HIGH_ADDR))
            begin
                rdata_reg <= addr_high_reg;
            end
            else if (hit(link.reg_addr, `BRK_ADDR_LOW_ADDR))
            begin
                rdata_reg <= addr_low_reg;
            end
            else if (hit(link.reg_addr, `BRK_STAT_CTRL_ADDR))
            begin
                rdata_reg[`BRK_ENABLE_BIT] <= break_enable_bit_reg;
                rdata_reg[`BRK_ACTIVE_BIT] <= break_active_bit_reg;
            end
            else if (hit(link.reg_addr, `BRK_LPE_STATUS_ADDR))
            begin
                rdata_reg[`BRK_LPE_FLAG_BIT] <=
                    low_power_exit_flag_reg;
            end
            else if (hit(link.reg_addr, `BRK_FLAG_CLR_ADDR))
            begin
                rdata_reg[`BRK_FCE_BIT] <= flag_clear_enable_reg;
            end
        end
    end

endmodule

// file: common/brk_regs.svh
`ifndef BRK_REGS_SVH
`define BRK_REGS_SVH

// Device register addresses on the CPU side
`define BRK_LPE_STATUS_ADDR 16'hfe00
`define BRK_FLAG_CLR_ADDR 16'hfe03
`define BRK_ADDR_HIGH_ADDR 16'hfe0c
`define BRK_ADDR_LOW_ADDR 16'hfe0d
`define BRK_STAT_CTRL_ADDR 16'hfe0e

// Device field positions
`define BRK_ENABLE_BIT 7
`define BRK_ACTIVE_BIT 6
`define BRK_LPE_FLAG_BIT 1
`define BRK_FCE_BIT 7

// Reset values
`define BRK_BYTE_RESET 8'h00
`define BRK_WORD_RESET 32'h0000_0000

// Break vectors
`define BRK_VECTOR_NORMAL 16'hfffc
`define BRK_VECTOR_MONITOR 16'hfefc

// Controller APB register offsets
`define BRK_C_CTRL_OFS 8'h00
`define BRK_C_FETCH_OFS 8'h04
`define BRK_C_REGACC_OFS 8'h08
`define BRK_C_STATUS_OFS 8'h0c
`define BRK_C_INT_STAT_OFS 8'h10
`define BRK_C_INT_MASK_OFS 8'h14
`define BRK_C_RTI_OFS 8'h18

// Controller field positions
`define BRK_C_STOP_BIT 0
`define BRK_C_WAIT_BIT 1
`define BRK_C_MON_BIT 2
`define BRK_C_LAST_BIT 16
`define BRK_C_WRITE_BIT 24
`define BRK_C_INT_ENTER_BIT 0
`define BRK_C_INT_WAKE_BIT 1
`define BRK_C_INT_READ_BIT 2

`endif

// file: common/brk_pkg.sv
package brk_pkg;

    // Break state of the device end
    typedef enum logic [0:0]
    {
        BRK_RUN = 1'b0,
        BRK_HALTED = 1'b1
    } brk_state_e;

    // Byte and address types
    typedef logic [7:0] brk_byte_t;
    typedef logic [15:0] brk_addr_t;

endpackage

// file: common/brk_link_if.sv
`timescale 1ns/10ps
interface brk_link_if;
    // Address bus compare inputs
    brk_pkg::brk_addr_t cpu_addr;
    logic addr_is_pc;
    logic instr_last;
    // Register access
    logic reg_wr;
    logic reg_rd;
    brk_pkg::brk_addr_t reg_addr;
    brk_pkg::brk_byte_t reg_wdata;
    brk_pkg::brk_byte_t reg_rdata;
    // Break handshake
    logic brk_req;
    logic swi_taken;
    logic rti_done;
    logic break_state;
    // Low power
    logic in_stop;
    logic in_wait;
    logic wake;

    modport dev
    (
        input cpu_addr, addr_is_pc, instr_last, reg_wr, reg_rd, reg_addr,
        input reg_wdata, swi_taken, rti_done, in_stop, in_wait,
        output reg_rdata, brk_req, break_state, wake
    );
    modport cpu
    (
        output cpu_addr, addr_is_pc, instr_last, reg_wr, reg_rd, reg_addr,
        output reg_wdata, swi_taken, rti_done, in_stop, in_wait,
        input reg_rdata, brk_req, break_state, wake
    );
endinterface

// file: core/brk_cpu_end.sv
`timescale 1ns/10ps
`include "brk_regs.svh"
module brk_cpu_end
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Link to the break unit
    brk_link_if.cpu link
);

    // APB write strobe for a given offset
    function automatic logic wsel(input logic [7:0] a, input logic [7:0] o,
                                  input logic s, input logic w);
        wsel = s && w && (a == o);
    endfunction

    logic [2:0] ctrl_reg;          // Stop, wait, monitor
    brk_pkg::brk_addr_t addr_reg;  // Fetch address
    logic last_reg;
    logic fetch_reg;               // One-cycle fetch strobe
    brk_pkg::brk_addr_t racc_addr_reg;
    brk_pkg::brk_byte_t racc_data_reg;
    logic racc_wr_reg;
    logic racc_rd_reg;
    logic rd_wait_reg;             // Read data due next cycle
    brk_pkg::brk_byte_t rd_data_reg;
    logic swi_reg;
    logic rti_reg;
    brk_pkg::brk_addr_t vector_reg;
    logic [2:0] int_stat_reg;
    logic [2:0] int_mask_reg;
    logic [31:0] prdata_reg;
    logic acc;                     // Access phase, write takes effect
    logic [2:0] int_set;

    assign acc = psel && penable;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_reg;
    assign irq = |(int_stat_reg & int_mask_reg);

    assign link.cpu_addr = addr_reg;
    assign link.addr_is_pc = fetch_reg;
    assign link.instr_last = fetch_reg && last_reg;
    assign link.reg_wr = racc_wr_reg;
    assign link.reg_rd = racc_rd_reg;
    assign link.reg_addr = racc_addr_reg;
    assign link.reg_wdata = racc_data_reg;
    assign link.swi_taken = swi_reg;
    assign link.rti_done = rti_reg;
    assign link.in_stop = ctrl_reg[`BRK_C_STOP_BIT];
    assign link.in_wait = ctrl_reg[`BRK_C_WAIT_BIT];

    assign int_set = {rd_wait_reg, link.wake, swi_reg};

    // Mode bits; a wake clears stop and wait and wins over software
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_reg <= 3'h0;
        end
        else if (link.wake)
        begin
            ctrl_reg[`BRK_C_STOP_BIT] <= 1'b0;
            ctrl_reg[`BRK_C_WAIT_BIT] <= 1'b0;
        end
        else if (wsel(paddr, `BRK_C_CTRL_OFS, acc, pwrite))
        begin
            ctrl_reg <= pwdata[2:0];
        end
    end

    // Fetch presentation: one cycle of program counter address
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            addr_reg <= 16'h0000;
            last_reg <= 1'b0;
            fetch_reg <= 1'b0;
        end
        else
        begin
            fetch_reg <= wsel(paddr, `BRK_C_FETCH_OFS, acc, pwrite);
            if (wsel(paddr, `BRK_C_FETCH_OFS, acc, pwrite))
            begin
                addr_reg <= pwdata[15:0];
                last_reg <= pwdata[`BRK_C_LAST_BIT];
            end
        end
    end

    // Device register access: one strobe cycle, read data one later
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            racc_addr_reg <= 16'h0000;
            racc_data_reg <= `BRK_BYTE_RESET;
            racc_wr_reg <= 1'b0;
            racc_rd_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
            rd_data_reg <= `BRK_BYTE_RESET;
        end
        else
        begin
            racc_wr_reg <= 1'b0;
            racc_rd_reg <= 1'b0;
            rd_wait_reg <= racc_rd_reg;
            if (wsel(paddr, `BRK_C_REGACC_OFS, acc, pwrite))
            begin
                racc_addr_reg <= pwdata[15:0];
                racc_data_reg <= pwdata[23:16];
                racc_wr_reg <= pwdata[`BRK_C_WRITE_BIT];
                racc_rd_reg <= !pwdata[`BRK_C_WRITE_BIT];
            end
            if (rd_wait_reg)
            begin
                rd_data_reg <= link.reg_rdata;
            end
        end
    end

    // Take the break the cycle after the request and pick the vector by mode
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            swi_reg <= 1'b0;
            rti_reg <= 1'b0;
            vector_reg <= 16'h0000;
        end
        else
        begin
            swi_reg <= link.brk_req && !swi_reg && !link.break_state;
            if (link.brk_req && !swi_reg && !link.break_state)
            begin
                vector_reg <= ctrl_reg[`BRK_C_MON_BIT] ?
                    `BRK_VECTOR_MONITOR : `BRK_VECTOR_NORMAL;
            end
            rti_reg <= wsel(paddr, `BRK_C_RTI_OFS, acc, pwrite)
                && link.break_state;
        end
    end

    // Sticky events, write one to clear, set wins
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            int_stat_reg <= 3'h0;
            int_mask_reg <= 3'h0;
        end
        else
        begin
            if (wsel(paddr, `BRK_C_INT_STAT_OFS, acc, pwrite))
            begin
                int_stat_reg <= (int_stat_reg & ~pwdata[2:0]) | int_set;
            end
            else
            begin
                int_stat_reg <= int_stat_reg | int_set;
            end
            if (wsel(paddr, `BRK_C_INT_MASK_OFS, acc, pwrite))
            begin
                int_mask_reg <= pwdata[2:0];
            end
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata_reg <= `BRK_WORD_RESET;
        end
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                `BRK_C_CTRL_OFS: prdata_reg <= {29'h0, ctrl_reg};
                `BRK_C_FETCH_OFS: prdata_reg <= {15'h0, last_reg, addr_reg};
                `BRK_C_REGACC_OFS: prdata_reg <= {24'h0, rd_data_reg};
                `BRK_C_STATUS_OFS:
                    prdata_reg <= {vector_reg, 14'h0, link.brk_req,
                                   link.break_state};
                `BRK_C_INT_STAT_OFS: prdata_reg <= {29'h0, int_stat_reg};
                `BRK_C_INT_MASK_OFS: prdata_reg <= {29'h0, int_mask_reg};
                default: prdata_reg <= `BRK_WORD_RESET;
            endcase
        end
    end

endmodule

// file: bench/brk_link_assertions.sv
`timescale 1ns/10ps
`include "brk_regs.svh"
module brk_link_assertions
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Compare and register side of the link
    input wire logic [15:0] cpu_addr,
    input wire logic addr_is_pc,
    input wire logic instr_last,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Break handshake and low power
    input wire logic brk_req,
    input wire logic swi_taken,
    input wire logic rti_done,
    input wire logic break_state,
    input wire logic in_stop,
    input wire logic in_wait,
    input wire logic wake
);
    // Shadow breakpoint and enable, kept from link writes
    logic [15:0] bp_reg;
    logic en_reg;
    // Software request seen on the link
    logic soft_wr;
    // Live match against the shadow
    logic hit;
    assign soft_wr = reg_wr && reg_addr == `BRK_STAT_CTRL_ADDR
        && reg_wdata[`BRK_ACTIVE_BIT];
    assign hit = addr_is_pc && en_reg && cpu_addr == bp_reg;

    // Shadow follows writes on the same edge as the device
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bp_reg <= 16'h0000;
            en_reg <= 1'b0;
        end
        else if (reg_wr)
        begin
            // Only the three breakpoint places matter here
            if (reg_addr == `BRK_ADDR_HIGH_ADDR)
                bp_reg[15:8] <= reg_wdata;
            if (reg_addr == `BRK_ADDR_LOW_ADDR)
                bp_reg[7:0] <= reg_wdata;
            if (reg_addr == `BRK_STAT_CTRL_ADDR)
                en_reg <= reg_wdata[`BRK_ENABLE_BIT];
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // Entry: the core takes the opcode, then the state holds
    sequence s_take;
        ##1 swi_taken ##1 (break_state && !brk_req);
    endsequence

    chk_no_req_break: assert property (break_state |-> !brk_req)
        else $error("request raised inside a break");
    chk_match_raises: assert property
        (hit && !break_state |-> brk_req)
        else $error("address match gave no request");
    chk_req_cause: assert property
        ($rose(brk_req) |-> hit || $past(soft_wr))
        else $error("request rose without a cause");
    chk_soft_break: assert property
        (soft_wr && !break_state && !brk_req |=> brk_req)
        else $error("active write gave no request");
    chk_enter_seq: assert property ($rose(brk_req) |-> s_take)
        else $error("break entry steps out of order");
    // A match on the last cycle of an instruction is taken at once
    chk_last_taken: assert property
        (hit && instr_last && !break_state && !swi_taken |=> swi_taken)
        else $error("last cycle match not taken at once");
    chk_rti_exit: assert property
        (break_state && rti_done |=> !break_state)
        else $error("break survived the return");
    chk_state_cause: assert property
        ($rose(break_state) |-> $past(swi_taken))
        else $error("break state without the opcode");
    chk_wake_level: assert property
        (wake == (brk_req && (in_stop || in_wait)))
        else $error("wake does not follow request");
    chk_ctrl_read: assert property
        (reg_rd && reg_addr == `BRK_STAT_CTRL_ADDR
        |=> reg_rdata[5:0] == 6'h00
        && reg_rdata[`BRK_ENABLE_BIT] == $past(en_reg))
        else $error("control byte read wrong");
    chk_exit_read: assert property
        (reg_rd && reg_addr == `BRK_LPE_STATUS_ADDR
        |=> (reg_rdata & ~(8'h01 << `BRK_LPE_FLAG_BIT)) == 8'h00)
        else $error("exit status reserved bits set");
    // Wake path reached
    cov_wake: cover property (wake);
endmodule

// file: bench/tb_brk_unit.sv
`timescale 1ns/10ps
`include "brk_regs.svh"
module tb_brk_unit;
    // Clock, reset and APB
    logic mclk;
    logic arst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    // Chip side of the device end
    logic test_high_voltage;
    logic timer_halt;
    logic watchdog_disable;
    logic flag_clear_allowed;
    // Bookkeeping; rd holds the last read word
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [15:0] rst_a [6] = '{16'hfe00, 16'hfe03, 16'hfe0c, 16'hfe0d,
                               16'hfe0e, 16'hfe01};

    brk_link_if link ();
    brk_unit brk_unit_i (.mclk(mclk), .arst_n(arst_n), .link(link),
        .test_high_voltage(test_high_voltage), .timer_halt(timer_halt),
        .watchdog_disable(watchdog_disable),
        .flag_clear_allowed(flag_clear_allowed));
    brk_cpu_end brk_cpu_end_i (.mclk(mclk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .link(link));
    brk_link_assertions brk_link_assertions_i (.mclk(mclk), .arst_n(arst_n),
        .cpu_addr(link.cpu_addr), .addr_is_pc(link.addr_is_pc),
        .instr_last(link.instr_last),
        .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
        .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
        .brk_req(link.brk_req), .swi_taken(link.swi_taken),
        .rti_done(link.rti_done), .break_state(link.break_state),
        .in_stop(link.in_stop), .in_wait(link.in_wait), .wake(link.wake));

    // Free running 10 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Ceiling well above the few hundred cycles the tests take
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Write, then let the link side settle before looking
    task automatic cmd(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (3) @(posedge mclk);
    endtask

    // Read a controller register under a mask
    task automatic ard(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd & m, e);
        // Zero wait and no error response on every read
        check({30'h0, pready, pslverr}, 32'h2);
    endtask

    // Device register access through the window
    task automatic dwr(input logic [15:0] a, input logic [7:0] d);
        cmd(`BRK_C_REGACC_OFS, {7'h00, 1'b1, d, a});
    endtask
    task automatic drd(input logic [15:0] a, input logic [7:0] e);
        cmd(`BRK_C_REGACC_OFS, {7'h00, 1'b0, 8'h00, a});
        ard(`BRK_C_REGACC_OFS, 32'hff, {24'h0, e});
    endtask

    // Program counter fetch with the last-cycle mark
    task automatic fetch(input logic [15:0] a);
        cmd(`BRK_C_FETCH_OFS, {15'h0, 1'b1, a});
    endtask

    // Single place where the run ends
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        test_high_voltage = 1'b0;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        // Reset values, an unmapped place among them
        foreach (rst_a[i]) drd(rst_a[i], 8'h00);
        ard(8'h1c, 32'hffffffff, 32'h0);
        check({31'h0, flag_clear_allowed}, 32'h1);
        $display("test reset done");
        // Address break; near misses on either byte first
        dwr(`BRK_ADDR_HIGH_ADDR, 8'h12);
        dwr(`BRK_ADDR_LOW_ADDR, 8'h34);
        dwr(`BRK_STAT_CTRL_ADDR, 8'h80);
        drd(`BRK_ADDR_HIGH_ADDR, 8'h12);
        drd(`BRK_ADDR_LOW_ADDR, 8'h34);
        fetch(16'h1334);
        fetch(16'h1235);
        ard(`BRK_C_STATUS_OFS, 32'h3, 32'h0);
        fetch(16'h1234);
        ard(`BRK_C_STATUS_OFS, 32'hffff0003, 32'hfffc0001);
        check({31'h0, timer_halt}, 32'h1);
        check({31'h0, watchdog_disable}, 32'h0);
        drd(`BRK_STAT_CTRL_ADDR, 8'hc0);
        fetch(16'h1234);
        ard(`BRK_C_STATUS_OFS, 32'h3, 32'h1);
        dwr(`BRK_STAT_CTRL_ADDR, 8'h80);
        drd(`BRK_STAT_CTRL_ADDR, 8'h80);
        cmd(`BRK_C_RTI_OFS, 32'h0);
        ard(`BRK_C_STATUS_OFS, 32'h3, 32'h0);
        check({31'h0, timer_halt}, 32'h0);
        $display("test match done");
        // Enable cleared: the same fetch passes
        dwr(`BRK_STAT_CTRL_ADDR, 8'h00);
        fetch(16'h1234);
        ard(`BRK_C_STATUS_OFS, 32'h3, 32'h0);
        $display("test enable done");
        // Software break in monitor mode, test voltage present
        test_high_voltage <= 1'b1;
        cmd(`BRK_C_CTRL_OFS, 32'h4);
        check({31'h0, watchdog_disable}, 32'h0);
        dwr(`BRK_STAT_CTRL_ADDR, 8'h40);
        ard(`BRK_C_STATUS_OFS, 32'hffff0001, 32'hfefc0001);
        check({31'h0, watchdog_disable}, 32'h1);
        check({31'h0, flag_clear_allowed}, 32'h0);
        dwr(`BRK_FLAG_CLR_ADDR, 8'h80);
        drd(`BRK_FLAG_CLR_ADDR, 8'h80);
        check({31'h0, flag_clear_allowed}, 32'h1);
        // Entry event, masked then unmasked, then cleared
        ard(`BRK_C_INT_STAT_OFS, 32'h1, 32'h1);
        check({31'h0, irq}, 32'h0);
        cmd(`BRK_C_INT_MASK_OFS, 32'h1);
        check({31'h0, irq}, 32'h1);
        cmd(`BRK_C_INT_STAT_OFS, 32'h7);
        check({31'h0, irq}, 32'h0);
        dwr(`BRK_STAT_CTRL_ADDR, 8'h00);
        dwr(`BRK_FLAG_CLR_ADDR, 8'h00);
        cmd(`BRK_C_RTI_OFS, 32'h0);
        check({31'h0, watchdog_disable}, 32'h0);
        test_high_voltage <= 1'b0;
        $display("test software done");
        // Break out of stop, then out of wait
        for (int m = 1; m <= 2; m++)
        begin
            cmd(`BRK_C_CTRL_OFS, m);
            dwr(`BRK_STAT_CTRL_ADDR, 8'h40);
            ard(`BRK_C_INT_STAT_OFS, 32'h2, 32'h2);
            ard(`BRK_C_CTRL_OFS, 32'h3, 32'h0);
            drd(`BRK_LPE_STATUS_ADDR, 8'h02);
            dwr(`BRK_LPE_STATUS_ADDR, 8'h02);
            drd(`BRK_LPE_STATUS_ADDR, 8'h02);
            dwr(`BRK_LPE_STATUS_ADDR, 8'h00);
            drd(`BRK_LPE_STATUS_ADDR, 8'h00);
            dwr(`BRK_STAT_CTRL_ADDR, 8'h00);
            cmd(`BRK_C_RTI_OFS, 32'h0);
            cmd(`BRK_C_INT_STAT_OFS, 32'h7);
        end
        $display("test low power done");
        report_and_stop();
    end
endmodule
